//--- common/fcsm_params.svh
// Command codes, widths and reset values of the flash command sequencer
`ifndef FCSM_PARAMS_SVH
`define FCSM_PARAMS_SVH

// ============================================================
// Bus widths
`define FCSM_DATA_W          16
`define FCSM_CMD_LSB         0
`define FCSM_CMD_MSB         7

// ============================================================
// Command codes (low byte of a host write)
`define FCSM_CMD_READ_ARRAY  8'hFF
`define FCSM_CMD_PROG_SETUP  8'h40
`define FCSM_CMD_PROG_ALT    8'h10
`define FCSM_CMD_ERASE_SETUP 8'h20
`define FCSM_CMD_CONFIRM     8'hD0
`define FCSM_CMD_SUSPEND     8'hB0
`define FCSM_CMD_READ_STATUS 8'h70
`define FCSM_CMD_CLR_STATUS  8'h50
`define FCSM_CMD_READ_IDENT  8'h90

// ============================================================
// Reset values
`define FCSM_PROG_WORD_RST   16'h0000

`endif

//--- common/fcsm_pkg.sv
// Types of the flash command sequencer: states, read sources, state record
package fcsm_pkg;

    // ============================================================
    // Command state machine states
    typedef enum logic [3:0] {
        FCSM_RD_ARRAY,
        FCSM_RD_STATUS,
        FCSM_RD_IDENT,
        FCSM_PROG_SETUP,
        FCSM_PROG_BUSY,
        FCSM_PS_STATUS,
        FCSM_PS_ARRAY,
        FCSM_PS_IDENT,
        FCSM_PROG_DONE,
        FCSM_ERS_SETUP,
        FCSM_ERS_ERR,
        FCSM_ERS_BUSY,
        FCSM_ES_STATUS,
        FCSM_ES_ARRAY,
        FCSM_ES_IDENT,
        FCSM_ERS_DONE
    } fcsm_st_t;

    // ============================================================
    // What a host read returns
    typedef enum logic [1:0] {
        FCSM_SRC_ARRAY,
        FCSM_SRC_STATUS,
        FCSM_SRC_IDENT
    } fcsm_src_t;

    // ============================================================
    // Whole state of the sequencer
    typedef struct packed {
        fcsm_st_t    st;
        logic [15:0] prog_word;
        logic        prog_start;
        logic        erase_start;
        logic        suspend;
        logic        resume;
        logic        seq_err;
        logic        erase_held;
    } fcsm_regs_t;

endpackage : fcsm_pkg

//--- core/fcsm_core.sv
// Command decode and operation state machine of a parallel boot-block flash
`timescale 1ns/1ps
`include "fcsm_params.svh"

module fcsm_core (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // Host write port
    input  wire logic                       cmd_we,
    input  wire logic [`FCSM_DATA_W-1:0]    cmd_data,
    // Operation engine
    input  wire logic                       op_done,
    output logic                            op_active,
    output logic                            op_is_erase,
    output logic                            prog_start,
    output logic                            erase_start,
    output logic                            op_suspend,
    output logic                            op_resume,
    output logic [`FCSM_DATA_W-1:0]         prog_word,
    // Read path and status
    output fcsm_pkg::fcsm_src_t             read_src,
    output logic                            status_ready_bit,
    output logic                            erase_seq_err
);

    // ============================================================
    // Decode helpers
    function automatic logic is_code(input logic [`FCSM_DATA_W-1:0] d, input logic [7:0] code);
        is_code = (d[`FCSM_CMD_MSB:`FCSM_CMD_LSB] == code);
    endfunction : is_code

    // Shared by every idle read state, including the done and error states
    function automatic fcsm_pkg::fcsm_st_t idle_next(input fcsm_pkg::fcsm_st_t cur,
                                                     input logic [`FCSM_DATA_W-1:0] d);
        idle_next = cur;
        if (is_code(d, `FCSM_CMD_READ_ARRAY)) begin
            idle_next = fcsm_pkg::FCSM_RD_ARRAY;
        end else if (is_code(d, `FCSM_CMD_PROG_SETUP) || is_code(d, `FCSM_CMD_PROG_ALT)) begin
            idle_next = fcsm_pkg::FCSM_PROG_SETUP;
        end else if (is_code(d, `FCSM_CMD_ERASE_SETUP)) begin
            idle_next = fcsm_pkg::FCSM_ERS_SETUP;
        end else if (is_code(d, `FCSM_CMD_SUSPEND) || is_code(d, `FCSM_CMD_CONFIRM)) begin
            idle_next = fcsm_pkg::FCSM_RD_ARRAY;
        end else if (is_code(d, `FCSM_CMD_READ_STATUS)) begin
            idle_next = fcsm_pkg::FCSM_RD_STATUS;
        end else if (is_code(d, `FCSM_CMD_CLR_STATUS)) begin
            idle_next = fcsm_pkg::FCSM_RD_ARRAY;
        end else if (is_code(d, `FCSM_CMD_READ_IDENT)) begin
            idle_next = fcsm_pkg::FCSM_RD_IDENT;
        end
    endfunction : idle_next

    // Read selection while an operation is suspended
    function automatic fcsm_pkg::fcsm_st_t susp_read(input fcsm_pkg::fcsm_st_t cur,
                                                     input logic [`FCSM_DATA_W-1:0] d,
                                                     input logic erase_side);
        susp_read = cur;
        if (is_code(d, `FCSM_CMD_READ_ARRAY) || is_code(d, `FCSM_CMD_SUSPEND)
            || is_code(d, `FCSM_CMD_CLR_STATUS)
            || (erase_side && is_code(d, `FCSM_CMD_ERASE_SETUP))) begin
            susp_read = erase_side ? fcsm_pkg::FCSM_ES_ARRAY : fcsm_pkg::FCSM_PS_ARRAY;
        end else if (is_code(d, `FCSM_CMD_READ_STATUS)) begin
            susp_read = erase_side ? fcsm_pkg::FCSM_ES_STATUS : fcsm_pkg::FCSM_PS_STATUS;
        end else if (is_code(d, `FCSM_CMD_READ_IDENT)) begin
            susp_read = erase_side ? fcsm_pkg::FCSM_ES_IDENT : fcsm_pkg::FCSM_PS_IDENT;
        end
    endfunction : susp_read

    // ============================================================
    // State
    fcsm_pkg::fcsm_regs_t regs_r;
    fcsm_pkg::fcsm_regs_t regs_nxt;

    logic in_prog_susp;
    logic in_ers_susp;
    logic in_busy;

    assign in_prog_susp = (regs_r.st == fcsm_pkg::FCSM_PS_STATUS) || (regs_r.st == fcsm_pkg::FCSM_PS_ARRAY)
                          || (regs_r.st == fcsm_pkg::FCSM_PS_IDENT);
    assign in_ers_susp  = (regs_r.st == fcsm_pkg::FCSM_ES_STATUS) || (regs_r.st == fcsm_pkg::FCSM_ES_ARRAY)
                          || (regs_r.st == fcsm_pkg::FCSM_ES_IDENT);
    assign in_busy      = (regs_r.st == fcsm_pkg::FCSM_PROG_BUSY) || (regs_r.st == fcsm_pkg::FCSM_ERS_BUSY);

    // ============================================================
    // Next state
    always_comb begin
        regs_nxt             = regs_r;
        regs_nxt.prog_start  = 1'b0;
        regs_nxt.erase_start = 1'b0;
        regs_nxt.suspend     = 1'b0;
        regs_nxt.resume      = 1'b0;
        case (regs_r.st)
            fcsm_pkg::FCSM_RD_ARRAY, fcsm_pkg::FCSM_RD_STATUS, fcsm_pkg::FCSM_RD_IDENT,
            fcsm_pkg::FCSM_PROG_DONE, fcsm_pkg::FCSM_ERS_ERR, fcsm_pkg::FCSM_ERS_DONE: begin
                if (cmd_we) begin
                    regs_nxt.st = idle_next(regs_r.st, cmd_data);
                    if (is_code(cmd_data, `FCSM_CMD_CLR_STATUS)) begin
                        regs_nxt.seq_err = 1'b0;
                    end
                end
            end
            fcsm_pkg::FCSM_PROG_SETUP: begin
                if (cmd_we) begin
                    // Any value is data here, even one that looks like a command
                    regs_nxt.prog_word  = cmd_data;
                    regs_nxt.prog_start = 1'b1;
                    regs_nxt.st         = fcsm_pkg::FCSM_PROG_BUSY;
                end
            end
            fcsm_pkg::FCSM_PROG_BUSY: begin
                // Completion outranks a write landing in the same cycle
                if (op_done) begin
                    regs_nxt.st = regs_r.erase_held ? fcsm_pkg::FCSM_ES_STATUS
                                                    : fcsm_pkg::FCSM_PROG_DONE;
                end else if (cmd_we && is_code(cmd_data, `FCSM_CMD_SUSPEND)) begin
                    regs_nxt.st      = fcsm_pkg::FCSM_PS_STATUS;
                    regs_nxt.suspend = 1'b1;
                end
            end
            fcsm_pkg::FCSM_PS_STATUS, fcsm_pkg::FCSM_PS_ARRAY, fcsm_pkg::FCSM_PS_IDENT: begin
                if (cmd_we) begin
                    if (is_code(cmd_data, `FCSM_CMD_CONFIRM)) begin
                        regs_nxt.st     = fcsm_pkg::FCSM_PROG_BUSY;
                        regs_nxt.resume = 1'b1;
                    end else begin
                        regs_nxt.st = susp_read(regs_r.st, cmd_data, 1'b0);
                    end
                end
            end
            fcsm_pkg::FCSM_ERS_SETUP: begin
                if (cmd_we) begin
                    if (is_code(cmd_data, `FCSM_CMD_CONFIRM)) begin
                        regs_nxt.st          = fcsm_pkg::FCSM_ERS_BUSY;
                        regs_nxt.erase_start = 1'b1;
                    end else begin
                        regs_nxt.st      = fcsm_pkg::FCSM_ERS_ERR;
                        regs_nxt.seq_err = 1'b1;
                    end
                end
            end
            fcsm_pkg::FCSM_ERS_BUSY: begin
                if (op_done) begin
                    regs_nxt.st = fcsm_pkg::FCSM_ERS_DONE;
                end else if (cmd_we && is_code(cmd_data, `FCSM_CMD_SUSPEND)) begin
                    regs_nxt.st         = fcsm_pkg::FCSM_ES_STATUS;
                    regs_nxt.suspend    = 1'b1;
                    regs_nxt.erase_held = 1'b1;
                end
            end
            fcsm_pkg::FCSM_ES_STATUS, fcsm_pkg::FCSM_ES_ARRAY, fcsm_pkg::FCSM_ES_IDENT: begin
                if (cmd_we) begin
                    if (is_code(cmd_data, `FCSM_CMD_CONFIRM)) begin
                        regs_nxt.st         = fcsm_pkg::FCSM_ERS_BUSY;
                        regs_nxt.resume     = 1'b1;
                        regs_nxt.erase_held = 1'b0;
                    end else if (is_code(cmd_data, `FCSM_CMD_PROG_SETUP)
                                 || is_code(cmd_data, `FCSM_CMD_PROG_ALT)) begin
                        regs_nxt.st = fcsm_pkg::FCSM_PROG_SETUP;
                    end else begin
                        regs_nxt.st = susp_read(regs_r.st, cmd_data, 1'b1);
                    end
                end
            end
            default: begin
                regs_nxt.st = fcsm_pkg::FCSM_RD_ARRAY;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regs_r.st          <= fcsm_pkg::FCSM_RD_ARRAY;
            regs_r.prog_word   <= `FCSM_PROG_WORD_RST;
            regs_r.prog_start  <= 1'b0;
            regs_r.erase_start <= 1'b0;
            regs_r.suspend     <= 1'b0;
            regs_r.resume      <= 1'b0;
            regs_r.seq_err     <= 1'b0;
            regs_r.erase_held  <= 1'b0;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // ============================================================
    // Outputs
    always_comb begin
        case (regs_r.st)
            fcsm_pkg::FCSM_RD_ARRAY, fcsm_pkg::FCSM_PS_ARRAY, fcsm_pkg::FCSM_ES_ARRAY: begin
                read_src = fcsm_pkg::FCSM_SRC_ARRAY;
            end
            fcsm_pkg::FCSM_RD_IDENT, fcsm_pkg::FCSM_PS_IDENT, fcsm_pkg::FCSM_ES_IDENT: begin
                read_src = fcsm_pkg::FCSM_SRC_IDENT;
            end
            default: begin
                read_src = fcsm_pkg::FCSM_SRC_STATUS;
            end
        endcase
    end

    // Ready is low only while the engine actually runs
    assign status_ready_bit = !in_busy;
    assign op_active        = in_busy;
    assign op_is_erase      = (regs_r.st == fcsm_pkg::FCSM_ERS_BUSY) || in_ers_susp;
    assign prog_start       = regs_r.prog_start;
    assign erase_start      = regs_r.erase_start;
    assign op_suspend       = regs_r.suspend;
    assign op_resume        = regs_r.resume;
    assign prog_word        = regs_r.prog_word;
    assign erase_seq_err    = regs_r.seq_err;

    // ============================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Idle read states decode commands alike
    logic in_idle;
    assign in_idle = (regs_r.st == fcsm_pkg::FCSM_RD_ARRAY) || (regs_r.st == fcsm_pkg::FCSM_RD_STATUS)
                     || (regs_r.st == fcsm_pkg::FCSM_RD_IDENT) || (regs_r.st == fcsm_pkg::FCSM_PROG_DONE)
                     || (regs_r.st == fcsm_pkg::FCSM_ERS_ERR) || (regs_r.st == fcsm_pkg::FCSM_ERS_DONE);

    sequence s_write(logic [7:0] code);
        cmd_we && is_code(cmd_data, code);
    endsequence

    sequence s_prog_running;
        (regs_r.st == fcsm_pkg::FCSM_PROG_BUSY) && !op_done;
    endsequence

    sequence s_ers_running;
        (regs_r.st == fcsm_pkg::FCSM_ERS_BUSY) && !op_done;
    endsequence

    a_busy_not_ready: assert property (in_busy |-> !status_ready_bit && read_src == fcsm_pkg::FCSM_SRC_STATUS)
        else $error("ready high or wrong read source while busy");

    a_prog_data_taken: assert property ((regs_r.st == fcsm_pkg::FCSM_PROG_SETUP) && cmd_we
        |=> prog_start && op_active && prog_word == $past(cmd_data) ##1 !prog_start)
        else $error("program data not taken as one start pulse");

    a_prog_ignore: assert property (s_prog_running ##0 (cmd_we && !is_code(cmd_data, `FCSM_CMD_SUSPEND))
        |=> regs_r.st == fcsm_pkg::FCSM_PROG_BUSY)
        else $error("command disturbed programming");

    a_prog_suspend: assert property (s_prog_running ##0 s_write(`FCSM_CMD_SUSPEND)
        |=> op_suspend && status_ready_bit && read_src == fcsm_pkg::FCSM_SRC_STATUS && !op_active)
        else $error("program suspend not entered");

    a_prog_resume: assert property (in_prog_susp ##0 s_write(`FCSM_CMD_CONFIRM)
        |=> op_resume && op_active && !op_is_erase)
        else $error("program resume failed");

    a_susp_no_start: assert property (in_prog_susp && cmd_we && !is_code(cmd_data, `FCSM_CMD_CONFIRM)
        |=> !op_active && !prog_start && !erase_start && status_ready_bit)
        else $error("operation started while program suspended");

    a_erase_confirm: assert property ((regs_r.st == fcsm_pkg::FCSM_ERS_SETUP) ##0 s_write(`FCSM_CMD_CONFIRM)
        |=> erase_start && op_is_erase && !status_ready_bit)
        else $error("erase not started on confirm");

    a_erase_seq_err: assert property ((regs_r.st == fcsm_pkg::FCSM_ERS_SETUP) && cmd_we
        && !is_code(cmd_data, `FCSM_CMD_CONFIRM) |=> erase_seq_err && !erase_start && status_ready_bit)
        else $error("bad erase sequence not flagged");

    a_erase_suspend: assert property (s_ers_running ##0 s_write(`FCSM_CMD_SUSPEND)
        |=> op_suspend && !op_active ##1 !op_suspend)
        else $error("erase suspend not entered");

    a_erase_resume: assert property (in_ers_susp ##0 s_write(`FCSM_CMD_CONFIRM)
        |=> op_resume && op_active && op_is_erase)
        else $error("erase resume failed");

    a_done_ready: assert property (in_busy && op_done |=> status_ready_bit
        && read_src == fcsm_pkg::FCSM_SRC_STATUS && !op_active)
        else $error("completion did not restore ready");

    a_idle_array: assert property (in_idle ##0 s_write(`FCSM_CMD_READ_ARRAY)
        |=> read_src == fcsm_pkg::FCSM_SRC_ARRAY && status_ready_bit)
        else $error("read array not selected");

    a_ers_susp_prog: assert property (in_ers_susp ##0 s_write(`FCSM_CMD_PROG_SETUP)
        |=> regs_r.st == fcsm_pkg::FCSM_PROG_SETUP ##0 regs_r.erase_held)
        else $error("program setup refused in erase suspend");

    a_idle_status: assert property (in_idle ##0 s_write(`FCSM_CMD_READ_STATUS)
        |=> read_src == fcsm_pkg::FCSM_SRC_STATUS && status_ready_bit)
        else $error("read status not selected");

    a_idle_ident: assert property (in_idle ##0 s_write(`FCSM_CMD_READ_IDENT)
        |=> read_src == fcsm_pkg::FCSM_SRC_IDENT && status_ready_bit)
        else $error("read identifier not selected");

    a_clear_status: assert property (in_idle ##0 s_write(`FCSM_CMD_CLR_STATUS)
        |=> read_src == fcsm_pkg::FCSM_SRC_ARRAY && !erase_seq_err)
        else $error("clear status did not clear or select array");

    a_prog_setup: assert property (in_idle ##0 (s_write(`FCSM_CMD_PROG_SETUP) or s_write(`FCSM_CMD_PROG_ALT))
        |=> regs_r.st == fcsm_pkg::FCSM_PROG_SETUP && read_src == fcsm_pkg::FCSM_SRC_STATUS && status_ready_bit)
        else $error("program setup not entered");

    a_erase_setup: assert property (in_idle ##0 s_write(`FCSM_CMD_ERASE_SETUP)
        |=> regs_r.st == fcsm_pkg::FCSM_ERS_SETUP && status_ready_bit && !op_active)
        else $error("erase setup not entered");

    a_idle_susp_cfm: assert property (in_idle ##0 (s_write(`FCSM_CMD_SUSPEND) or s_write(`FCSM_CMD_CONFIRM))
        |=> read_src == fcsm_pkg::FCSM_SRC_ARRAY && !op_active && !op_suspend && !op_resume)
        else $error("idle suspend or confirm not read array");

    a_ers_ignore: assert property (s_ers_running ##0 (cmd_we && !is_code(cmd_data, `FCSM_CMD_SUSPEND))
        |=> regs_r.st == fcsm_pkg::FCSM_ERS_BUSY)
        else $error("command disturbed erasing");

    a_ers_susp_read: assert property (in_ers_susp ##0 s_write(`FCSM_CMD_ERASE_SETUP)
        |=> regs_r.st == fcsm_pkg::FCSM_ES_ARRAY && op_is_erase && !op_active)
        else $error("erase setup in erase suspend not array read");

    a_ers_done: assert property ((regs_r.st == fcsm_pkg::FCSM_ERS_BUSY) && op_done
        |=> regs_r.st == fcsm_pkg::FCSM_ERS_DONE && status_ready_bit && !op_is_erase)
        else $error("erase completion not reported");

endmodule : fcsm_core

//--- testbench/fcsm_engine_model.sv
// Behavioural operation engine that answers the sequencer's program and erase runs
`timescale 1ns/1ps

module fcsm_engine_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Sequencer side
    input  wire logic       op_active,
    input  wire logic       prog_start,
    input  wire logic       erase_start,
    // Run length chosen by the bench, zero answers at once
    input  wire logic [7:0] run_len,
    output logic            op_done
);
    logic [7:0] cnt_r;

    // Counts only while running, so a suspend freezes progress
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 8'h00;
            op_done <= 1'h0;
        end else begin
            op_done <= 1'h0;
            if (prog_start || erase_start) begin
                cnt_r <= 8'h00;
            end else if (op_active && !op_done) begin
                // Guard keeps it to one pulse per run
                if (cnt_r >= run_len) begin
                    op_done <= 1'h1;
                    cnt_r   <= 8'h00;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
        end
    end
endmodule : fcsm_engine_model

//--- testbench/tb_fcsm_core.sv
// Self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`include "fcsm_params.svh"

module tb_fcsm_core;
    logic                mclk, rst_n, cmd_we, op_done, op_active, op_is_erase, prog_start;
    logic                erase_start, op_suspend, op_resume, status_ready_bit, erase_seq_err;
    logic [15:0]         cmd_data, prog_word, c_word;
    logic [7:0]          run_len;
    fcsm_pkg::fcsm_src_t read_src, c_src;
    // Outputs captured one step after the edge that took a write
    logic                c_rdy, c_act, c_ers, c_err, c_pst, c_est, c_sus, c_res;
    int                  failures, n_tests;
    localparam fcsm_pkg::fcsm_src_t ARR = fcsm_pkg::FCSM_SRC_ARRAY;
    localparam fcsm_pkg::fcsm_src_t STS = fcsm_pkg::FCSM_SRC_STATUS;
    localparam fcsm_pkg::fcsm_src_t IDN = fcsm_pkg::FCSM_SRC_IDENT;

    fcsm_core fcsm_core_inst (.mclk(mclk), .rst_n(rst_n), .cmd_we(cmd_we), .cmd_data(cmd_data),
        .op_done(op_done), .op_active(op_active), .op_is_erase(op_is_erase), .prog_start(prog_start),
        .erase_start(erase_start), .op_suspend(op_suspend), .op_resume(op_resume), .prog_word(prog_word),
        .read_src(read_src), .status_ready_bit(status_ready_bit), .erase_seq_err(erase_seq_err));
    fcsm_engine_model fcsm_engine_model_inst (.mclk(mclk), .rst_n(rst_n), .op_active(op_active),
        .prog_start(prog_start), .erase_start(erase_start), .run_len(run_len), .op_done(op_done));

    // =========================================================
    // Shared tasks
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic grab();
        c_src = read_src;
        {c_rdy, c_act, c_ers, c_err} = {status_ready_bit, op_active, op_is_erase, erase_seq_err};
        {c_pst, c_est, c_sus, c_res} = {prog_start, erase_start, op_suspend, op_resume};
        c_word = prog_word;
    endtask : grab

    // Called on an edge; returns on the second edge after
    task automatic wr(input logic [15:0] d);
        cmd_we   <= 1'h1;
        cmd_data <= d;
        @(posedge mclk);
        cmd_we <= 1'h0;
        #1;
        grab();
        @(posedge mclk);
    endtask : wr

    task automatic ex(input fcsm_pkg::fcsm_src_t s, input logic r, input logic a);
        chk(16'(c_src), 16'(s));
        chk({15'h0000, c_rdy}, {15'h0000, r});
        chk({15'h0000, c_act}, {15'h0000, a});
    endtask : ex

    // Idle-style decode: no operation may start
    task automatic step(input logic [7:0] code, input fcsm_pkg::fcsm_src_t s);
        wr({8'h00, code});
        ex(s, 1'h1, 1'h0);
        chk({15'h0000, c_pst | c_est}, 16'h0000);
    endtask : step

    task automatic wait_done();
        int i;
        for (i = 0; i < 300; i++) begin
            #1;
            grab();
            if (c_rdy === 1'h1) break;
            @(posedge mclk);
        end
        if (i == 300) begin
            failures++;
            results();
        end
        @(posedge mclk);
    endtask : wait_done

    // =========================================================
    // Scenarios
    task automatic t_reset();
        #1;
        grab();
        ex(ARR, 1'h1, 1'h0);
        chk(c_word, 16'h0000);
        chk({15'h0000, c_err}, 16'h0000);
        @(posedge mclk);
    endtask : t_reset

    task automatic t_idle();
        step(`FCSM_CMD_READ_STATUS, STS);
        step(8'h33, STS);
        step(`FCSM_CMD_READ_IDENT, IDN);
        step(8'h33, IDN);
        step(`FCSM_CMD_SUSPEND, ARR);
        step(`FCSM_CMD_READ_STATUS, STS);
        step(`FCSM_CMD_READ_ARRAY, ARR);
        step(`FCSM_CMD_READ_IDENT, IDN);
        step(`FCSM_CMD_CLR_STATUS, ARR);
        step(`FCSM_CMD_CONFIRM, ARR);
        step(`FCSM_CMD_SUSPEND, ARR);
    endtask : t_idle

    task automatic t_program(input logic [7:0] code, input logic [15:0] word, input logic [7:0] len);
        run_len <= len;
        wr({8'h00, code});
        ex(STS, 1'h1, 1'h0);
        wr(word);
        ex(STS, 1'h0, 1'h1);
        chk({15'h0000, c_pst}, 16'h0001);
        chk(c_word, word);
        wait_done();
        ex(STS, 1'h1, 1'h0);
        step(`FCSM_CMD_READ_IDENT, IDN);
    endtask : t_program

    task automatic t_prog_susp();
        run_len <= 8'h1E;
        wr({8'h00, `FCSM_CMD_PROG_SETUP});
        wr(16'h5A5A);
        wr({8'h00, `FCSM_CMD_READ_ARRAY});
        ex(STS, 1'h0, 1'h1);
        wr({8'h00, `FCSM_CMD_SUSPEND});
        ex(STS, 1'h1, 1'h0);
        chk({15'h0000, c_sus}, 16'h0001);
        step(`FCSM_CMD_READ_ARRAY, ARR);
        step(`FCSM_CMD_PROG_SETUP, ARR);
        step(`FCSM_CMD_READ_IDENT, IDN);
        step(`FCSM_CMD_ERASE_SETUP, IDN);
        step(`FCSM_CMD_READ_STATUS, STS);
        step(`FCSM_CMD_PROG_ALT, STS);
        step(`FCSM_CMD_SUSPEND, ARR);
        step(`FCSM_CMD_READ_STATUS, STS);
        step(`FCSM_CMD_CLR_STATUS, ARR);
        wr({8'h00, `FCSM_CMD_CONFIRM});
        ex(STS, 1'h0, 1'h1);
        chk({15'h0000, c_res}, 16'h0001);
        wait_done();
        ex(STS, 1'h1, 1'h0);
    endtask : t_prog_susp

    task automatic t_erase();
        run_len <= 8'h28;
        wr({8'h00, `FCSM_CMD_ERASE_SETUP});
        ex(STS, 1'h1, 1'h0);
        wr({8'h00, `FCSM_CMD_CONFIRM});
        ex(STS, 1'h0, 1'h1);
        chk({14'h0000, c_est, c_ers}, 16'h0003);
        wr({8'h00, `FCSM_CMD_PROG_SETUP});
        ex(STS, 1'h0, 1'h1);
        wr({8'h00, `FCSM_CMD_SUSPEND});
        ex(STS, 1'h1, 1'h0);
        chk({15'h0000, c_sus}, 16'h0001);
        step(`FCSM_CMD_ERASE_SETUP, ARR);
        step(`FCSM_CMD_READ_STATUS, STS);
        step(`FCSM_CMD_READ_IDENT, IDN);
        step(`FCSM_CMD_CLR_STATUS, ARR);
        step(`FCSM_CMD_READ_IDENT, IDN);
        step(`FCSM_CMD_SUSPEND, ARR);
        wr({8'h00, `FCSM_CMD_PROG_SETUP});
        ex(STS, 1'h1, 1'h0);
        wr(16'h0F0F);
        chk({15'h0000, c_pst}, 16'h0001);
        wait_done();
        ex(STS, 1'h1, 1'h0);
        chk({15'h0000, c_ers}, 16'h0001);
        wr({8'h00, `FCSM_CMD_CONFIRM});
        ex(STS, 1'h0, 1'h1);
        chk({14'h0000, c_res, c_ers}, 16'h0003);
        wait_done();
        ex(STS, 1'h1, 1'h0);
        chk({15'h0000, c_ers}, 16'h0000);
        step(`FCSM_CMD_READ_IDENT, IDN);
    endtask : t_erase

    task automatic t_erase_err();
        logic [7:0] bad [5];
        bad = '{`FCSM_CMD_READ_ARRAY, `FCSM_CMD_PROG_SETUP, `FCSM_CMD_SUSPEND, `FCSM_CMD_READ_STATUS, 8'h20};
        foreach (bad[i]) begin
            wr({8'h00, `FCSM_CMD_ERASE_SETUP});
            wr({8'h00, bad[i]});
            ex(STS, 1'h1, 1'h0);
            chk({14'h0000, c_err, c_est}, 16'h0002);
            step(`FCSM_CMD_CLR_STATUS, ARR);
            chk({15'h0000, c_err}, 16'h0000);
        end
    endtask : t_erase_err

    // =========================================================
    // Clock and main sequence
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        {rst_n, cmd_we, cmd_data, run_len} = {1'h0, 1'h0, 16'h0000, 8'h14};
        failures = 0;
        n_tests  = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        t_reset();
        t_idle();
        t_program(`FCSM_CMD_PROG_SETUP, 16'h12B0, 8'h14);
        t_program(`FCSM_CMD_PROG_ALT, 16'hFFFF, 8'h00);
        t_prog_susp();
        t_erase();
        t_erase_err();
        results();
    end
endmodule : tb_fcsm_core
